// file: logic/qcm_monitor.sv
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`include "qcm_regs.svh"
// Functional notes
// - period tick bumps period counter when congested
// - on packet arrival, over depth increments counter
// - leak tick decrements congestion counter
// - error-rate-bias tick also decrements congestion counter
// - writing one to depth alarm clears counter
// - period counter clears only on read
// - counter above alarm level sets depth alarm
// - non-head fabric pick increments reorder count
// - reorder count above limit sets reorder alarm
// - ingress queue has identical monitoring set
// - separate ingress and egress depth alarms
// - egress alarm may request port-write notification
module qcm_monitor (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire qcm_pkg::qcm_queue_s egressQueue,
	input wire qcm_pkg::qcm_queue_s ingressQueue,
	input wire logic reorderPick,
	input wire logic biasTick,
	output logic irq,
	output logic portWriteReq
);
	logic [31:0] depthCfg_reg [0:1];
	logic [15:0] alarmLevel_reg [0:1];
	logic [31:0] periodCnt_reg [0:1];
	qcm_pkg::qcm_cnt_t congCnt_reg [0:1];
	qcm_pkg::qcm_tmr_t leakTmr_reg [0:1];
	qcm_pkg::qcm_tmr_t periodTmr_reg [0:1];
	qcm_pkg::qcm_cnt_t reorderCnt_reg;
	qcm_pkg::qcm_cnt_t reorderLimit_reg;
	logic [2:0] intStatus_reg;
	logic [2:0] intStatus_next;
	logic [2:0] intMask_reg;
	logic [0:0] ctrl_reg;
	logic [31:0] prdata_reg;
	logic portWrite_reg;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// a timer with a zero interval stays idle
	function automatic logic timerDone(qcm_pkg::qcm_tmr_t cnt, qcm_pkg::qcm_tmr_t limit);
		timerDone = (limit != 12'h000) && (cnt >= limit - 12'h001);
	endfunction

	function automatic qcm_pkg::qcm_tmr_t timerNext(qcm_pkg::qcm_tmr_t cnt,
			qcm_pkg::qcm_tmr_t limit);
		timerNext = timerDone(cnt, limit) || (limit == 12'h000) ? 12'h000 : cnt + 12'h001;
	endfunction

	function automatic logic hit(logic [7:0] addr, logic [7:0] off);
		hit = (addr[7:2] == off[7:2]);
	endfunction

	// signed step on a 16-bit counter, clamped at zero and all-ones
	function automatic qcm_pkg::qcm_cnt_t satStep(qcm_pkg::qcm_cnt_t cur, logic inc,
			logic [1:0] dec);
		logic [17:0] sum;
		sum = {2'b00, cur} + {17'h00000, inc};
		if (sum < {16'h0000, dec}) begin
			satStep = 16'h0000;
		end else if (sum - {16'h0000, dec} > 18'h0ffff) begin
			satStep = 16'hffff;
		end else begin
			satStep = 16'(sum - {16'h0000, dec});
		end
	endfunction

	wire qcm_pkg::qcm_queue_s queueIn [0:1];
	assign queueIn[0] = egressQueue;
	assign queueIn[1] = ingressQueue;

	wire setupPhase = psel && !penable;
	wire accessPhase = psel && penable;
	wire wrAccess = accessPhase && pwrite;
	wire rdAccess = accessPhase && !pwrite;

	wire selEgDepth = hit(paddr, `QCM_EG_DEPTH_OFF);
	wire selEgPeriod = hit(paddr, `QCM_EG_PERIOD_OFF);
	wire selEgStatus = hit(paddr, `QCM_EG_STATUS_OFF);
	wire selReorder = hit(paddr, `QCM_REORDER_OFF);
	wire selInDepth = hit(paddr, `QCM_IN_DEPTH_OFF);
	wire selInPeriod = hit(paddr, `QCM_IN_PERIOD_OFF);
	wire selInStatus = hit(paddr, `QCM_IN_STATUS_OFF);
	wire selIntStatus = hit(paddr, `QCM_INT_STATUS_OFF);
	wire selIntMask = hit(paddr, `QCM_INT_MASK_OFF);
	wire selCtrl = hit(paddr, `QCM_CTRL_OFF);
	wire mapped = selEgDepth || selEgPeriod || selEgStatus || selReorder || selInDepth ||
		selInPeriod || selInStatus || selIntStatus || selIntMask || selCtrl;

	wire selDepth [0:1];
	wire selPeriod [0:1];
	wire selStatus [0:1];
	assign selDepth[0] = selEgDepth;
	assign selDepth[1] = selInDepth;
	assign selPeriod[0] = selEgPeriod;
	assign selPeriod[1] = selInPeriod;
	assign selStatus[0] = selEgStatus;
	assign selStatus[1] = selInStatus;

	// zero wait states; unmapped addresses answer with an error and read as zero
	assign pready = 1'b1;
	assign pslverr = accessPhase && !mapped;
	assign prdata = prdata_reg;
	assign irq = |(intStatus_reg & intMask_reg);
	assign portWriteReq = portWrite_reg;

	wire intClear [0:2];
	wire depthAlarm [0:1];
	wire [2:0] intEvent;
	genvar b;
	for (b = 0; b < 3; b++) begin : gClr
		assign intClear[b] = wrAccess && selIntStatus && pwdata[b];
	end

	wire reorderAlarm = reorderCnt_reg > reorderLimit_reg;
	// an alarm whose counter this very write empties is no new event
	assign intEvent = {reorderAlarm && !intClear[2], depthAlarm[1] && !intClear[1],
		depthAlarm[0] && !intClear[0]};

	// any other set beats the write-one clear in the same cycle
	always_comb begin
		intStatus_next = intStatus_reg;
		if (wrAccess && selIntStatus) begin
			intStatus_next = intStatus_reg & ~pwdata[2:0];
		end
		intStatus_next = intStatus_next | intEvent;
	end

	wire periodInc [0:1];
	wire arriveInc [0:1];
	wire leakTick [0:1];

	genvar q;
	for (q = 0; q < 2; q++) begin : gQueue
		wire qcm_pkg::qcm_occ_t depth = depthCfg_reg[q][`QCM_DEPTH_MSB:`QCM_DEPTH_LSB];
		wire qcm_pkg::qcm_tmr_t leakLimit = depthCfg_reg[q][`QCM_LEAK_MSB:`QCM_LEAK_LSB];
		wire qcm_pkg::qcm_tmr_t periodLimit = depthCfg_reg[q][`QCM_PERIOD_MSB:`QCM_PERIOD_LSB];
		wire periodTick = timerDone(periodTmr_reg[q], periodLimit);
		wire [1:0] decCount = {1'b0, leakTick[q]} + {1'b0, biasTick};
		wire periodRead = rdAccess && selPeriod[q];
		assign leakTick[q] = timerDone(leakTmr_reg[q], leakLimit);
		assign arriveInc[q] = queueIn[q].arrive && (queueIn[q].occupancy > depth);
		assign periodInc[q] = periodTick && (congCnt_reg[q] != 16'h0000);
		assign depthAlarm[q] = congCnt_reg[q] > alarmLevel_reg[q];

		always_ff @(posedge clk) begin
			if (sys_rst) begin
				depthCfg_reg[q] <= `QCM_DEPTH_CFG_RST;
				alarmLevel_reg[q] <= `QCM_LEVEL_RST;
				periodCnt_reg[q] <= 32'h0000_0000;
				congCnt_reg[q] <= 16'h0000;
				leakTmr_reg[q] <= 12'h000;
				periodTmr_reg[q] <= 12'h000;
			end else begin
				leakTmr_reg[q] <= timerNext(leakTmr_reg[q], leakLimit);
				periodTmr_reg[q] <= timerNext(periodTmr_reg[q], periodLimit);
				if (wrAccess && selDepth[q]) begin
					depthCfg_reg[q] <= pwdata;
				end
				if (wrAccess && selStatus[q]) begin
					alarmLevel_reg[q] <= pwdata[`QCM_LEVEL_MSB:`QCM_LEVEL_LSB];
				end
				// a write-one to the depth alarm bit empties the counter
				if (intClear[q]) begin
					congCnt_reg[q] <= 16'h0000;
				end else begin
					congCnt_reg[q] <= satStep(congCnt_reg[q], arriveInc[q], decCount);
				end
				// subtract what the read returned so a tick after the capture is kept
				if (periodRead) begin
					periodCnt_reg[q] <= periodCnt_reg[q] - prdata_reg +
						{31'h0000_0000, periodInc[q]};
				end else if (periodInc[q] && periodCnt_reg[q] != 32'hffff_ffff) begin
					periodCnt_reg[q] <= periodCnt_reg[q] + 32'h0000_0001;
				end
			end
		end

		a_period_tick: assert property (
				periodInc[q] && !periodRead && periodCnt_reg[q] != 32'hffff_ffff |=>
				periodCnt_reg[q] == $past(periodCnt_reg[q]) + 32'h0000_0001)
			else $error("period counter missed a tick");

		a_period_gate: assert property (
				periodTick && congCnt_reg[q] == 16'h0000 && !periodRead |=>
				$stable(periodCnt_reg[q]))
			else $error("period counter moved while not congested");

		a_period_hold: assert property (
				!periodInc[q] && !periodRead |=> $stable(periodCnt_reg[q]))
			else $error("period counter changed by itself");

		a_read_clear: assert property (
				setupPhase && selPeriod[q] && !pwrite && !periodInc[q] ##1
				periodRead && !periodInc[q] |=> periodCnt_reg[q] == 32'h0000_0000)
			else $error("period counter not cleared by read");

		a_period_sat: assert property (
				periodCnt_reg[q] == 32'hffff_ffff && !periodRead |=>
				periodCnt_reg[q] == 32'hffff_ffff)
			else $error("period counter wrapped");

		a_depth_inc: assert property (
				arriveInc[q] && !leakTick[q] && !biasTick && !intClear[q] &&
				congCnt_reg[q] != 16'hffff |=>
				congCnt_reg[q] == $past(congCnt_reg[q]) + 16'h0001)
			else $error("arrival over depth did not count");

		a_depth_hold: assert property (
				!arriveInc[q] && !leakTick[q] && !biasTick && !intClear[q] |=>
				$stable(congCnt_reg[q]))
			else $error("congestion counter moved without an event");

		a_leak_dec: assert property (
				leakTick[q] && !arriveInc[q] && !biasTick && !intClear[q] &&
				congCnt_reg[q] != 16'h0000 |=>
				congCnt_reg[q] == $past(congCnt_reg[q]) - 16'h0001)
			else $error("leak tick did not decrement");

		a_bias_dec: assert property (
				biasTick && !leakTick[q] && !arriveInc[q] && !intClear[q] &&
				congCnt_reg[q] != 16'h0000 |=>
				congCnt_reg[q] == $past(congCnt_reg[q]) - 16'h0001)
			else $error("bias tick did not decrement");

		a_double_dec: assert property (
				leakTick[q] && biasTick && !arriveInc[q] && !intClear[q] &&
				congCnt_reg[q] > 16'h0001 |=>
				congCnt_reg[q] == $past(congCnt_reg[q]) - 16'h0002)
			else $error("leak and bias ticks did not both count");

		a_clear_count: assert property (intClear[q] |=> congCnt_reg[q] == 16'h0000)
			else $error("depth alarm clear left counter");

		a_alarm_set: assert property (
				depthAlarm[q] && !intClear[q] |=> intStatus_reg[q])
			else $error("depth alarm bit not set");

		a_alarm_sticky: assert property (
				intStatus_reg[q] && !intClear[q] |=> intStatus_reg[q])
			else $error("depth alarm bit dropped without a clear");

		a_no_underflow: assert property (
				congCnt_reg[q] == 16'h0000 && !arriveInc[q] |=>
				congCnt_reg[q] == 16'h0000)
			else $error("congestion counter went below zero");

		a_count_sat: assert property (
				congCnt_reg[q] == 16'hffff && arriveInc[q] && !leakTick[q] && !biasTick &&
				!intClear[q] |=> congCnt_reg[q] == 16'hffff)
			else $error("congestion counter wrapped");

		a_inc_dec_cancel: assert property (
				arriveInc[q] && leakTick[q] && !biasTick && !intClear[q] |=>
				$stable(congCnt_reg[q]))
			else $error("balanced step changed counter");

		a_cfg_write: assert property (
				wrAccess && selDepth[q] |=> depthCfg_reg[q] == $past(pwdata))
			else $error("depth threshold write lost");

		c_alarm_raise: cover property (depthAlarm[q] && !intStatus_reg[q]);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reorderCnt_reg <= 16'h0000;
			reorderLimit_reg <= `QCM_LEVEL_RST;
		end else begin
			if (wrAccess && selReorder) begin
				reorderLimit_reg <= pwdata[`QCM_LEVEL_MSB:`QCM_LEVEL_LSB];
			end
			// cleared together with its alarm, like the depth counters
			if (intClear[`QCM_REORDER_BIT]) begin
				reorderCnt_reg <= 16'h0000;
			end else begin
				reorderCnt_reg <= satStep(reorderCnt_reg, reorderPick, 2'b00);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			intStatus_reg <= 3'h0;
			intMask_reg <= `QCM_INT_MASK_RST;
			ctrl_reg <= `QCM_CTRL_RST;
			portWrite_reg <= 1'b0;
		end else begin
			intStatus_reg <= intStatus_next;
			if (wrAccess && selIntMask) begin
				intMask_reg <= pwdata[2:0];
			end
			if (wrAccess && selCtrl) begin
				ctrl_reg <= pwdata[`QCM_PW_ENABLE_BIT:`QCM_PW_ENABLE_BIT];
			end
			// one request per rising edge of the egress alarm bit
			portWrite_reg <= ctrl_reg[0] && intStatus_next[`QCM_EG_DEPTH_BIT] &&
				!intStatus_reg[`QCM_EG_DEPTH_BIT];
		end
	end

	// read data captured in the setup cycle, presented through the access phase
	wire [31:0] rdMux = selEgDepth ? depthCfg_reg[0] :
		selEgPeriod ? periodCnt_reg[0] :
		selEgStatus ? {alarmLevel_reg[0], congCnt_reg[0]} :
		selReorder ? {reorderLimit_reg, reorderCnt_reg} :
		selInDepth ? depthCfg_reg[1] :
		selInPeriod ? periodCnt_reg[1] :
		selInStatus ? {alarmLevel_reg[1], congCnt_reg[1]} :
		selIntStatus ? {29'h0000_0000, intStatus_reg} :
		selIntMask ? {29'h0000_0000, intMask_reg} :
		selCtrl ? {31'h0000_0000, ctrl_reg} : 32'h0000_0000;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prdata_reg <= 32'h0000_0000;
		end else if (setupPhase) begin
			prdata_reg <= pwrite ? 32'h0000_0000 : rdMux;
		end
	end

	a_reorder_inc: assert property (
			reorderPick && !intClear[2] && reorderCnt_reg != 16'hffff |=>
			reorderCnt_reg == $past(reorderCnt_reg) + 16'h0001)
		else $error("reorder pick not counted");

	a_reorder_hold: assert property (
			!reorderPick && !intClear[2] |=> $stable(reorderCnt_reg))
		else $error("reorder count moved without a pick");

	a_reorder_alarm: assert property (
			reorderAlarm && !intClear[2] |=> intStatus_reg[`QCM_REORDER_BIT])
		else $error("reorder alarm not set");

	a_reorder_clear: assert property (intClear[2] |=> reorderCnt_reg == 16'h0000)
		else $error("reorder alarm clear left count");

	a_irq_level: assert property ((intStatus_reg & intMask_reg) != 3'h0 |-> irq)
		else $error("unmasked status without interrupt");

	a_irq_quiet: assert property ((intStatus_reg & intMask_reg) == 3'h0 |-> !irq)
		else $error("interrupt without unmasked status");

	a_pw_pulse: assert property (portWriteReq |=> !portWriteReq)
		else $error("port-write request longer than one cycle");

	a_pw_cause: assert property (portWriteReq |-> intStatus_reg[0] && $past(ctrl_reg[0]) &&
			!$past(intStatus_reg[0]))
		else $error("port-write request without rising alarm");

	a_pw_off: assert property (!ctrl_reg[0] |=> !portWriteReq)
		else $error("port-write request while disabled");

	a_rdata_hold: assert property (!setupPhase |=> $stable(prdata))
		else $error("read data moved outside a setup cycle");

	c_reorder_alarm: cover property (reorderAlarm ##1 irq);
	c_port_write: cover property (portWriteReq);
	c_period_read: cover property (rdAccess && selEgPeriod && periodCnt_reg[0] != 32'h0);
endmodule

// file: logic/qcm_pkg.sv
package qcm_pkg;
	typedef logic [7:0] qcm_occ_t;
	typedef logic [15:0] qcm_cnt_t;
	typedef logic [11:0] qcm_tmr_t;

	// one monitored queue: packet fully arrived pulse and current packet count
	typedef struct packed {
		logic arrive;
		qcm_occ_t occupancy;
	} qcm_queue_s;
endpackage

// file: logic/qcm_regs.svh
`ifndef QCM_REGS_SVH
`define QCM_REGS_SVH

// register byte offsets
`define QCM_EG_DEPTH_OFF 8'h00
`define QCM_EG_PERIOD_OFF 8'h04
`define QCM_EG_STATUS_OFF 8'h08
`define QCM_REORDER_OFF 8'h0c
`define QCM_IN_DEPTH_OFF 8'h10
`define QCM_IN_PERIOD_OFF 8'h14
`define QCM_IN_STATUS_OFF 8'h18
`define QCM_INT_STATUS_OFF 8'h1c
`define QCM_INT_MASK_OFF 8'h20
`define QCM_CTRL_OFF 8'h24

// depth threshold register fields
`define QCM_DEPTH_LSB 0
`define QCM_DEPTH_MSB 7
`define QCM_LEAK_LSB 8
`define QCM_LEAK_MSB 19
`define QCM_PERIOD_LSB 20
`define QCM_PERIOD_MSB 31

// status and reorder register fields
`define QCM_COUNT_LSB 0
`define QCM_COUNT_MSB 15
`define QCM_LEVEL_LSB 16
`define QCM_LEVEL_MSB 31

// interrupt bits and the port-write enable bit
`define QCM_EG_DEPTH_BIT 0
`define QCM_IN_DEPTH_BIT 1
`define QCM_REORDER_BIT 2
`define QCM_PW_ENABLE_BIT 0

// reset values
`define QCM_DEPTH_CFG_RST 32'h0000_0000
`define QCM_LEVEL_RST 16'hffff
`define QCM_INT_MASK_RST 3'h0
`define QCM_CTRL_RST 1'h0

`endif

// file: tb/test_queue_congestion_monitor.sv
`timescale 1ns/1ps
`include "qcm_regs.svh"
module test_queue_congestion_monitor;
	logic clk = 1'b0;
	logic sysRst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	qcm_pkg::qcm_queue_s egressQueue = '0;
	qcm_pkg::qcm_queue_s ingressQueue = '0;
	logic reorderPick = 1'b0;
	logic biasTick = 1'b0;
	logic irq;
	logic portWriteReq;
	logic errSeen;
	logic [31:0] q;
	int failCount = 0;
	int testsRun = 0;
	int pwCount = 0;

	qcm_monitor qcm_monitor_i (.clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .egressQueue(egressQueue), .ingressQueue(ingressQueue),
		.reorderPick(reorderPick), .biasTick(biasTick), .irq(irq), .portWriteReq(portWriteReq));

	always #12.5 clk = ~clk;

	always @(posedge clk) begin
		if (portWriteReq === 1'b1)
			pwCount <= pwCount + 1;
	end

	task automatic finishTest();
		$display("checks %0d, mismatches %0d", testsRun, failCount);
		if (failCount == 0 && testsRun > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [7:0] id);
		testsRun++;
		if (got !== exp) begin
			$display("Error at %0t: check %h got %h expected %h", $time, id, got, exp);
			failCount++;
		end
	endtask

	// entered just after a rising edge; leaves one idle cycle so strobes never re-rise at once
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			failCount++;
			finishTest();
		end
		q = prdata;
		errSeen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp, a);
	endtask

	// one arrival pulse, optionally with a bias tick, then one quiet cycle
	task automatic arrive(input logic ing, input qcm_pkg::qcm_occ_t occ, input logic bias);
		if (ing)
			ingressQueue <= '{arrive: 1'b1, occupancy: occ};
		else
			egressQueue <= '{arrive: 1'b1, occupancy: occ};
		biasTick <= bias;
		@(posedge clk);
		ingressQueue.arrive <= 1'b0;
		egressQueue.arrive <= 1'b0;
		biasTick <= 1'b0;
		@(posedge clk);
	endtask

	task automatic t_reset();
		chk(irq, 1'b0, 8'he0);
		rd(`QCM_EG_DEPTH_OFF, `QCM_DEPTH_CFG_RST);
		rd(`QCM_IN_STATUS_OFF, {`QCM_LEVEL_RST, 16'h0000});
		rd(`QCM_REORDER_OFF, 32'hffff_0000);
		rd(`QCM_INT_MASK_OFF, 32'h0);
		rd(`QCM_CTRL_OFF, 32'h0);
		rd(8'h28, 32'h0);
		chk(errSeen, 1'b1, 8'he1);
		wr(`QCM_EG_STATUS_OFF, 32'h0000_00ff);
		rd(`QCM_EG_STATUS_OFF, 32'h0);
	endtask

	task automatic t_depth(input logic ing);
		logic [7:0] cfg;
		logic [7:0] sts;
		logic [31:0] bitv;
		cfg = ing ? `QCM_IN_DEPTH_OFF : `QCM_EG_DEPTH_OFF;
		sts = ing ? `QCM_IN_STATUS_OFF : `QCM_EG_STATUS_OFF;
		bitv = ing ? 32'h0000_0002 : 32'h0000_0001;
		wr(cfg, 32'h0000_0004);
		wr(sts, 32'h0001_0000);
		arrive(ing, 8'h04, 1'b0);
		arrive(ing, 8'h05, 1'b0);
		rd(`QCM_INT_STATUS_OFF, 32'h0);
		arrive(ing, 8'h05, 1'b0);
		rd(sts, 32'h0001_0002);
		rd(`QCM_INT_STATUS_OFF, bitv);
		chk(irq, 1'b0, 8'he2);
		wr(`QCM_INT_MASK_OFF, bitv);
		chk(irq, 1'b1, 8'he3);
		wr(`QCM_INT_STATUS_OFF, bitv);
		rd(sts, 32'h0001_0000);
		rd(`QCM_INT_STATUS_OFF, 32'h0);
		chk(irq, 1'b0, 8'he4);
		wr(`QCM_INT_MASK_OFF, 32'h0);
		chk(pwCount, 32'd1, 8'he5);
	endtask

	task automatic t_reorder();
		wr(`QCM_REORDER_OFF, 32'h0002_0000);
		for (int i = 1; i <= 3; i++) begin
			reorderPick <= 1'b1;
			@(posedge clk);
			reorderPick <= 1'b0;
			rd(`QCM_REORDER_OFF, {16'h0002, 16'(i)});
			rd(`QCM_INT_STATUS_OFF, (i > 2) ? 32'h4 : 32'h0);
		end
		wr(`QCM_INT_STATUS_OFF, 32'h4);
		rd(`QCM_REORDER_OFF, 32'h0002_0000);
		rd(`QCM_INT_STATUS_OFF, 32'h0);
	endtask

	task automatic t_timers();
		wr(`QCM_EG_DEPTH_OFF, 32'h0);
		repeat (3) arrive(1'b0, 8'h01, 1'b0);
		arrive(1'b0, 8'h00, 1'b1);
		arrive(1'b0, 8'h01, 1'b1);
		rd(`QCM_EG_STATUS_OFF, 32'h0001_0002);
		wr(`QCM_EG_DEPTH_OFF, 32'h0050_0000);
		repeat (50) @(posedge clk);
		apb(1'b0, `QCM_EG_PERIOD_OFF, 32'h0);
		chk(q > 32'd7 && q < 32'd12, 1'b1, 8'he6);
		apb(1'b0, `QCM_EG_PERIOD_OFF, 32'h0);
		chk(q < 32'd2, 1'b1, 8'he7);
		wr(`QCM_EG_DEPTH_OFF, 32'h0000_0400);
		repeat (30) @(posedge clk);
		arrive(1'b0, 8'h00, 1'b1);
		rd(`QCM_EG_STATUS_OFF, 32'h0001_0000);
		apb(1'b0, `QCM_EG_PERIOD_OFF, 32'h0);
		wr(`QCM_EG_DEPTH_OFF, 32'h0050_0400);
		repeat (30) @(posedge clk);
		rd(`QCM_EG_PERIOD_OFF, 32'h0);
	endtask

	initial begin
		repeat (8) @(posedge clk);
		sysRst <= 1'b0;
		@(posedge clk);
		t_reset();
		wr(`QCM_CTRL_OFF, 32'h1);
		t_depth(1'b0);
		t_depth(1'b1);
		t_reorder();
		t_timers();
		finishTest();
	end
endmodule
